// file: src/reg_domain_defines.vh
`ifndef REG_DOMAIN_DEFINES_VH
`define REG_DOMAIN_DEFINES_VH

// Domain state codes, one-hot.
`define DOM_GLOBAL        4'h1
`define DOM_US            4'h2
`define DOM_EUROPE        4'h4
`define DOM_LOCKED        4'h8

// Domain output encoding.
`define DOMAIN_CODE_GLOBAL 2'h0
`define DOMAIN_CODE_US     2'h1
`define DOMAIN_CODE_EUROPE 2'h2
`define DOMAIN_CODE_LOCKED 2'h3

// Scan sequencer states, one-hot.
`define SEQ_START         3'h1
`define SEQ_SCAN          3'h2
`define SEQ_WAIT          3'h4

// Non-US result count that selects the European domain.
`define EUROPE_THRESHOLD  2'h3

// Highest permitted channels.
`define CHAN_MAX_NARROW   4'hb
`define CHAN_MAX_WIDE     4'hd
`define CHAN_MASK_NARROW  13'h07ff
`define CHAN_MASK_WIDE    13'h1fff

// MAC address low-bit selectors.
`define MAC_SEL_WIRELESS  2'h0
`define MAC_SEL_WIRED     2'h1

// Rescan interval: one hour in seconds, clock 200 MHz.
`define RESCAN_SECONDS    64'd3600
`define CLOCK_HZ          64'd200000000

`endif

// file: src/regulatory_domain_selector.v
`timescale 1ns/1ps
`include "reg_domain_defines.vh"

module regulatory_domain_selector #(
    parameter [63:0] RESCAN_CYCLES = `RESCAN_SECONDS * `CLOCK_HZ,
    parameter [47:0] MAC_BASE      = 48'h0a0b0c000000
) (
    input  wire        mclk,
    input  wire        resetn,
    input  wire        ap_mode,
    input  wire        force_global,
    input  wire        scan_done,
    input  wire        beacon_valid,
    input  wire        beacon_has_country,
    input  wire        beacon_is_us,
    input  wire [3:0]  beacon_rate,
    input  wire [3:0]  beacon_chan_count,
    input  wire [7:0]  beacon_rssi,
    input  wire [7:0]  beacon_max_power,
    output reg         scan_active,
    output reg         tx_inhibit,
    output reg  [1:0]  domain,
    output reg  [3:0]  max_channel,
    output reg  [12:0] channel_mask,
    output reg         list_filtered,
    output reg  [7:0]  best_rssi,
    output reg  [7:0]  best_max_power,
    output reg  [3:0]  best_rate,
    output reg  [3:0]  best_chan_count,
    output reg         best_is_us,
    output reg  [47:0] mac_wireless,
    output reg  [47:0] mac_wired
);

    reg [3:0]  dom_reg;
    reg [3:0]  dom_next;
    reg [2:0]  seq_reg;
    reg [63:0] timer_reg;
    reg [1:0]  nonus_count_reg;
    reg        us_seen_reg;
    reg        scans_done_reg;
    reg        first_done_reg;
    reg        best_valid_reg;

    // Pin inputs other than resetn pass two flip-flops first.
    reg  [29:0] in_meta;
    reg  [29:0] in_sync;
    wire [29:0] in_raw = {ap_mode, force_global, scan_done, beacon_valid,
                          beacon_has_country, beacon_is_us, beacon_rate,
                          beacon_chan_count, beacon_rssi, beacon_max_power};
    always @(posedge mclk) begin
        if (!resetn) begin
            in_meta <= 30'h0;
            in_sync <= 30'h0;
        end else begin
            in_meta <= in_raw;
            in_sync <= in_meta;
        end
    end

    wire       s_ap_mode = in_sync[29];
    wire       s_force   = in_sync[28];
    wire       s_done    = in_sync[27];
    wire       s_valid   = in_sync[26];
    wire       s_country = in_sync[25];
    wire       s_us      = in_sync[24];
    wire [3:0] s_rate    = in_sync[23:20];
    wire [3:0] s_chans   = in_sync[19:16];
    wire [7:0] s_rssi    = in_sync[15:8];
    wire [7:0] s_power   = in_sync[7:0];

    wire scanning = seq_reg[2'd1];
    wire beacon_take = scanning && s_valid;
    wire scan_end = scanning && s_done;

    // Scan sequencer: startup scan, then one per hour.
    always @(posedge mclk) begin
        if (!resetn) begin
            seq_reg   <= `SEQ_START;
            timer_reg <= 64'h0;
        end else begin
            case (seq_reg)
                `SEQ_START: begin
                    seq_reg <= `SEQ_SCAN;
                end
                `SEQ_SCAN: begin
                    if (s_done) begin
                        seq_reg   <= `SEQ_WAIT;
                        timer_reg <= 64'h0;
                    end
                end
                `SEQ_WAIT: begin
                    if (timer_reg >= RESCAN_CYCLES - 64'h1) begin
                        seq_reg   <= `SEQ_SCAN;
                        timer_reg <= 64'h0;
                    end else begin
                        timer_reg <= timer_reg + 64'h1;
                    end
                end
                default: begin
                    seq_reg <= `SEQ_START;
                end
            endcase
        end
    end

    // Evidence gathered across scans.
    always @(posedge mclk) begin
        if (!resetn) begin
            nonus_count_reg <= 2'h0;
            us_seen_reg     <= 1'b0;
            scans_done_reg  <= 1'b0;
        end else if (beacon_take && s_country) begin
            if (s_us) begin
                us_seen_reg <= 1'b1;
            end else if (nonus_count_reg != `EUROPE_THRESHOLD) begin
                nonus_count_reg <= nonus_count_reg + 2'h1;
            end
        end else if (scan_end) begin
            scans_done_reg <= 1'b1;
        end
    end

    wire saw_us    = us_seen_reg || (beacon_take && s_country && s_us);
    wire saw_nonus = (nonus_count_reg != 2'h0) || (beacon_take && s_country && !s_us);

    // Domain decision, taken at each scan end; force_global returns it to global in any cycle unless it is locked.
    always @* begin
        dom_next = dom_reg;
        case (dom_reg)
            `DOM_GLOBAL, `DOM_US, `DOM_EUROPE: begin
                if (s_force) begin
                    dom_next = `DOM_GLOBAL;
                end else if (scan_end) begin
                    if (saw_us && saw_nonus) begin
                        dom_next = `DOM_LOCKED;
                    end else if (saw_us) begin
                        dom_next = `DOM_US;
                    end else if (nonus_count_reg == `EUROPE_THRESHOLD) begin
                        dom_next = `DOM_EUROPE;
                    end
                end
            end
            `DOM_LOCKED: begin
                dom_next = `DOM_LOCKED;
            end
            default: begin
                dom_next = `DOM_GLOBAL;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            dom_reg        <= `DOM_GLOBAL;
            first_done_reg <= 1'b0;
        end else begin
            dom_reg <= dom_next;
            if (scan_end) begin
                first_done_reg <= 1'b1;
            end
        end
    end

    // Best access point by signal strength; its domain follows.
    always @(posedge mclk) begin
        if (!resetn) begin
            best_valid_reg  <= 1'b0;
            best_rssi       <= 8'h00;
            best_max_power  <= 8'h00;
            best_rate       <= 4'h0;
            best_chan_count <= 4'h0;
            best_is_us      <= 1'b0;
        end else if (beacon_take && (!best_valid_reg || s_rssi > best_rssi)) begin
            best_valid_reg  <= 1'b1;
            best_rssi       <= s_rssi;
            best_max_power  <= s_power;
            best_rate       <= s_rate;
            best_chan_count <= s_chans;
            best_is_us      <= s_country && s_us;
        end
    end

    // Channel list, mode limit and scan status.
    wire wide = dom_reg[2] && first_done_reg && !s_ap_mode;
    always @(posedge mclk) begin
        if (!resetn) begin
            scan_active   <= 1'b0;
            tx_inhibit    <= 1'b0;
            domain        <= `DOMAIN_CODE_GLOBAL;
            max_channel   <= `CHAN_MAX_NARROW;
            channel_mask  <= `CHAN_MASK_NARROW;
            list_filtered <= 1'b0;
            mac_wireless  <= 48'h0;
            mac_wired     <= 48'h0;
        end else begin
            scan_active   <= scanning;
            tx_inhibit    <= scanning && !s_ap_mode;
            list_filtered <= first_done_reg;
            case (dom_reg)
                `DOM_US:     domain <= `DOMAIN_CODE_US;
                `DOM_EUROPE: domain <= `DOMAIN_CODE_EUROPE;
                `DOM_LOCKED: domain <= `DOMAIN_CODE_LOCKED;
                default:     domain <= `DOMAIN_CODE_GLOBAL;
            endcase
            if (wide) begin
                max_channel  <= `CHAN_MAX_WIDE;
                channel_mask <= `CHAN_MASK_WIDE;
            end else begin
                max_channel  <= `CHAN_MAX_NARROW;
                channel_mask <= `CHAN_MASK_NARROW;
            end
            mac_wireless <= {MAC_BASE[47:2], `MAC_SEL_WIRELESS};
            mac_wired    <= {MAC_BASE[47:2], `MAC_SEL_WIRED};
        end
    end

endmodule // regulatory_domain_selector

// file: test/reg_domain_props.sv
`timescale 1ns/1ps
module reg_domain_props (
    input wire        mclk,
    input wire        resetn,
    input wire        ap_mode,
    input wire        scan_active,
    input wire        tx_inhibit,
    input wire [1:0]  domain,
    input wire [3:0]  max_channel,
    input wire [12:0] channel_mask,
    input wire        list_filtered,
    input wire [47:0] mac_wireless,
    input wire [47:0] mac_wired
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_start_global: assert property ($rose(resetn) |-> domain == 2'h0)
        else $error("domain not global after reset");
    chk_locked_holds: assert property (domain == 2'h3 |=> domain == 2'h3)
        else $error("locked domain left");
    chk_narrow_chan: assert property (domain != 2'h2 |-> max_channel == 4'hb)
        else $error("channel limit wrong outside european domain");
    chk_mask_match: assert property (channel_mask == ((max_channel == 4'hd) ? 13'h1fff : 13'h07ff))
        else $error("channel mask disagrees with limit");
    chk_ap_narrow: assert property (ap_mode [*5] |-> max_channel == 4'hb)
        else $error("access point mode above channel 11");
    chk_tx_scan: assert property (tx_inhibit |-> scan_active)
        else $error("transmit inhibited outside a scan");
    chk_wide_filtered: assert property (max_channel == 4'hd |-> list_filtered)
        else $error("wide list before first scan");
    chk_mac_pair: assert property (list_filtered |-> mac_wired == {mac_wireless[47:2], 2'h1})
        else $error("wired address not next to wireless");
    chk_filter_sticky: assert property (list_filtered |=> list_filtered)
        else $error("filtered flag dropped");
    cover property (domain == 2'h1);
    cover property (domain == 2'h2);
    cover property (domain == 2'h3);
    cover property (ap_mode && domain == 2'h2);
endmodule // reg_domain_props
bind regulatory_domain_selector reg_domain_props u_props (.*);

// file: test/beacon_source.sv
`timescale 1ns/1ps
module beacon_source (
    input  wire       mclk,
    output reg        beacon_valid,
    output reg        beacon_has_country,
    output reg        beacon_is_us,
    output reg  [3:0] beacon_rate,
    output reg  [3:0] beacon_chan_count,
    output reg  [7:0] beacon_rssi,
    output reg  [7:0] beacon_max_power,
    output reg        scan_done
);
    initial begin
        {beacon_valid, beacon_has_country, beacon_is_us, scan_done} = 4'h0;
        {beacon_rate, beacon_chan_count, beacon_rssi, beacon_max_power} = 24'h0;
    end
    // One beacon for one cycle, then the fields are scrambled.
    task send(input logic us, input logic [7:0] rssi);
        begin
            @(posedge mclk);
            {beacon_valid, beacon_has_country, beacon_is_us} <= {2'h3, us};
            {beacon_rate, beacon_chan_count, beacon_rssi, beacon_max_power} <= {rssi[3:0], 4'hb, rssi, ~rssi};
            @(posedge mclk);
            {beacon_valid, beacon_has_country, beacon_is_us} <= {1'b0, 1'b0, ~us};
            {beacon_rate, beacon_chan_count, beacon_rssi, beacon_max_power} <= ~{rssi[3:0], 4'hb, rssi, ~rssi};
        end
    endtask
    // Reports the end of the scan.
    task end_scan;
        begin
            @(posedge mclk);
            scan_done <= 1'b1;
            @(posedge mclk);
            scan_done <= 1'b0;
        end
    endtask
endmodule // beacon_source

// file: test/regulatory_domain_selector_tb.sv
`timescale 1ns/1ps
module regulatory_domain_selector_tb;
    localparam [47:0] MB = 48'h123456789a00;
    reg         mclk = 1'b0, resetn = 1'b0, ap_mode = 1'b0, force_global = 1'b0;
    wire        beacon_valid, beacon_has_country, beacon_is_us, scan_done;
    wire [3:0]  beacon_rate, beacon_chan_count, best_rate, best_chan_count, max_channel;
    wire [7:0]  beacon_rssi, beacon_max_power, best_rssi, best_max_power;
    wire        scan_active, tx_inhibit, list_filtered, best_is_us;
    wire [1:0]  domain;
    wire [12:0] channel_mask;
    wire [47:0] mac_wireless, mac_wired;
    int         error_cnt = 0, total_checks = 0, cyc = 0;
    beacon_source u_ap (.*);
    regulatory_domain_selector #(.RESCAN_CYCLES(64'd100), .MAC_BASE(MB)) u_dut (.*);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task results;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task check(input string what, input logic [47:0] exp, input logic [47:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task do_reset;
        @(posedge mclk) resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    // Waits for a scan, sends beacons, ends it and judges the domain.
    task scan(input logic [1:0] exp, input int nus, input int neu);
        int i;
        i = 0;
        while (scan_active !== 1'b1 && i < 400) begin
            @(negedge mclk);
            i++;
        end
        // Let the synchronised mode pin reach the registered inhibit first.
        repeat (2) @(negedge mclk);
        check("scan_active", 1'b1, scan_active);
        check("tx_inhibit", !ap_mode, tx_inhibit);
        for (i = 0; i < nus; i++) u_ap.send(1'b1, 8'h20 + i[7:0]);
        for (i = 0; i < neu; i++) u_ap.send(1'b0, 8'h40 + i[7:0]);
        u_ap.end_scan();
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        check("domain", exp, domain);
        check("max_channel", (exp == 2'h2 && !ap_mode) ? 4'hd : 4'hb, max_channel);
        check("list_filtered", 1'b1, list_filtered);
    endtask
    task t_startup;
        do_reset();
        check("domain", 2'h0, domain);
        check("channel_mask", 13'h07ff, channel_mask);
        check("list_filtered", 1'b0, list_filtered);
        check("mac_wireless", {MB[47:2], 2'h0}, mac_wireless);
        check("mac_wired", {MB[47:2], 2'h1}, mac_wired);
    endtask
    task t_us;
        scan(2'h1, 2, 0);
        check("best_rssi", 8'h21, best_rssi);
        check("best_is_us", 1'b1, best_is_us);
        check("best_max_power", 8'hde, best_max_power);
        check("best_rate", 4'h1, best_rate);
        check("best_chan_count", 4'hb, best_chan_count);
    endtask
    task t_europe_lock;
        do_reset();
        scan(2'h0, 0, 2);
        scan(2'h2, 0, 1);
        check("channel_mask", 13'h1fff, channel_mask);
        scan(2'h3, 1, 0);
        scan(2'h3, 0, 3);
        do_reset();
        check("domain", 2'h0, domain);
    endtask
    task t_ap_force;
        ap_mode <= 1'b1;
        do_reset();
        scan(2'h2, 0, 3);
        ap_mode <= 1'b0;
        force_global <= 1'b1;
        do_reset();
        scan(2'h0, 0, 3);
        force_global <= 1'b0;
    endtask
    initial begin
        t_startup();
        t_us();
        t_europe_lock();
        t_ap_force();
        results();
    end
endmodule // regulatory_domain_selector_tb
